//--- logic/usct_pkg.sv
// usct_pkg: register map, field positions, reset values and states of the serial port
// assumes: an 8-bit register port with a 3-bit address
package usct_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CSA = 3'h0;
  localparam logic [2:0] ADDR_CSB = 3'h1;
  localparam logic [2:0] ADDR_CSC = 3'h2;
  localparam logic [2:0] ADDR_DIR = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h5;
  localparam logic [2:0] ADDR_DATA = 3'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CSA_RX_DONE = 7;
  localparam int CSA_TX_DONE = 6;
  localparam int CSA_TX_EMPTY = 5;
  localparam int CSA_FRAME_ERR = 4;
  localparam int CSA_DOUBLE = 1;
  localparam int CSB_RX_EN = 4;
  localparam int CSB_TX_EN = 3;
  localparam int CSB_CS2 = 2;
  localparam int CSB_RX_BIT8 = 1;
  localparam int CSB_TX_BIT8 = 0;
  localparam int CSC_SYNC = 6;
  localparam int CSC_PAR_LO = 4;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_CS_LO = 1;
  localparam int CSC_POL = 0;
  localparam int DIR_MASTER = 0;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_RESET = 3'h3;
  localparam logic [2:0] CS_9BIT = 3'h7;
  localparam logic [1:0] PAR_RESET = 2'h0;
  localparam logic [11:0] BAUD_RESET = 12'h000;
  localparam logic [3:0] NORM_TOP = 4'hf;
  localparam logic [3:0] DOUBLE_TOP = 4'h7;
  localparam logic [3:0] NORM_MID = 4'h7;
  localparam logic [3:0] DOUBLE_MID = 4'h3;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } usct_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_RUN = 2'b10
  } usct_rx_state_type;

endpackage : usct_pkg

//--- logic/usct_baud_gen.sv
// usct_baud_gen: programmable down-counter that paces serial timing in async and synchronous master modes (slave follows the external clock)
// assumes: divisor and load pulse are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module usct_baud_gen #(
  parameter int DIV_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic [DIV_W-1:0] divisor,
  input wire logic load,
  // pacing
  output logic tick
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic at_zero;

  assign at_zero = (cnt_reg == '0);
  assign cnt_next = (at_zero || load) ? divisor : cnt_reg - 1'b1;
  assign tick = at_zero;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  a_baud_reload: assert property (@(posedge clk) disable iff (!rst_b)
    (at_zero || load) |=> (cnt_reg == $past(divisor)))
    else $error("baud counter did not reload from divisor");

endmodule : usct_baud_gen
`default_nettype wire

//--- logic/usct_top.sv
// usct_top: serial port clock generation, frame transmitter and frame receiver
// assumes: serial_rx_pin and xfer_clock_in are synchronous to clk; register port never waits
`timescale 1ns/1ps
`default_nettype none
module usct_top import usct_pkg::*; #(
  parameter int DIV_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial data pins
  input wire logic serial_rx_pin,
  output logic serial_tx_out,
  output logic serial_tx_oe,
  // transfer clock pin
  input wire logic xfer_clock_in,
  output logic xfer_clock_out,
  output logic xfer_clock_oe
);

  default clocking dclk @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic double_speed_sel, tx_done_flag, rx_done_flag, framing_error;
  logic rx_en_reg, tx_enable_bit, rx_bit8_reg, tx_bit8_reg;
  logic sync_mode_sel, stop_bits_sel, clock_polarity_sel, xfer_clock_dir;
  logic [2:0] char_size_field;
  logic [1:0] parity_mode_field;
  logic [DIV_W-1:0] baud_divisor;
  logic [8:0] data_buffer_reg;
  logic buf_full_reg;
  logic [8:0] rx_data_reg;
  logic [7:0] rdata_reg;

  logic wr_csa, wr_csb, wr_csc, wr_dir, wr_lo, wr_hi, wr_data, rd_data;
  assign wr_csa = reg_wr && (reg_addr == ADDR_CSA);
  assign wr_csb = reg_wr && (reg_addr == ADDR_CSB);
  assign wr_csc = reg_wr && (reg_addr == ADDR_CSC);
  assign wr_dir = reg_wr && (reg_addr == ADDR_DIR);
  assign wr_lo = reg_wr && (reg_addr == ADDR_BAUD_LO);
  assign wr_hi = reg_wr && (reg_addr == ADDR_BAUD_HI);
  assign wr_data = reg_wr && (reg_addr == ADDR_DATA);
  assign rd_data = reg_rd && (reg_addr == ADDR_DATA);

  // ----------------------------------------------------------------
  // shared frame format
  // ----------------------------------------------------------------
  logic [3:0] data_n, frame_len, stop_pos;
  logic [8:0] data_mask;
  logic par_en, par_odd;
  assign data_n = (char_size_field == CS_9BIT) ? 4'h9 :
                  (char_size_field[2] ? 4'h8 : {1'b0, char_size_field} + 4'h5);
  assign par_en = parity_mode_field[1];
  assign par_odd = parity_mode_field[0];
  assign data_mask = 9'h1ff >> (4'h9 - data_n);
  // both directions read the same fields, so a change mid-frame hits both
  assign frame_len = data_n + {3'h0, par_en} + {3'h0, stop_bits_sel} + 4'h2;
  assign stop_pos = data_n + {3'h0, par_en} + 4'h1;

  // ----------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------
  logic baud_tick;
  usct_baud_gen #(.DIV_W(DIV_W)) usct_baud_gen_i (
    .clk(clk),
    .rst_b(rst_b),
    .divisor(baud_divisor),
    .load(wr_lo),
    .tick(baud_tick)
  );

  logic xck_int_reg, xs1_reg, xs2_reg, xs3_reg;
  logic [3:0] ps_reg;
  logic [3:0] ps_top, rx_mid;
  logic xck_rise, xck_fall, change_edge, sample_edge, async_bit_en, tx_bit_en;

  // master clock toggles each baud tick: divide by two of the tick rate, 2*(divisor+1) of clk overall
  assign xck_rise = xfer_clock_dir ? (baud_tick && !xck_int_reg) : (xs2_reg && !xs3_reg);
  assign xck_fall = xfer_clock_dir ? (baud_tick && xck_int_reg) : (!xs2_reg && xs3_reg);
  assign change_edge = clock_polarity_sel ? xck_fall : xck_rise;
  assign sample_edge = clock_polarity_sel ? xck_rise : xck_fall;
  assign ps_top = double_speed_sel ? DOUBLE_TOP : NORM_TOP;
  assign rx_mid = double_speed_sel ? DOUBLE_MID : NORM_MID;
  assign async_bit_en = baud_tick && (ps_reg == ps_top);
  // synchronous path never looks at the double speed bit
  assign tx_bit_en = sync_mode_sel ? change_edge : async_bit_en;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xck_int_reg <= 1'b0;
      xs1_reg <= 1'b0;
      xs2_reg <= 1'b0;
      xs3_reg <= 1'b0;
      ps_reg <= 4'h0;
    end else begin
      xck_int_reg <= xck_int_reg ^ baud_tick;
      xs1_reg <= xfer_clock_in;
      xs2_reg <= xs1_reg;
      xs3_reg <= xs2_reg;
      if (baud_tick) begin
        ps_reg <= (ps_reg >= ps_top) ? 4'h0 : ps_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  usct_tx_state_type tx_state;
  logic [3:0] tx_idx_reg;
  logic [8:0] tx_shift_reg;
  logic tx_line_reg, tx_oe_reg, xck_oe_reg;
  logic tx_last, tx_load, tx_done_ev, tx_parity, tx_bit, tx_busy;

  assign tx_busy = (tx_state == TX_SEND);
  assign tx_last = tx_busy && (tx_idx_reg == frame_len);
  // pending data still goes out after enable is dropped
  assign tx_load = tx_bit_en && buf_full_reg && (tx_enable_bit || tx_oe_reg) &&
                   (!tx_busy || tx_last);
  assign tx_done_ev = tx_bit_en && tx_last && !tx_load;
  assign tx_parity = (^tx_shift_reg) ^ par_odd;
  assign tx_bit = (tx_idx_reg <= data_n) ? tx_shift_reg[4'(tx_idx_reg - 4'h1)] :
                  (par_en && (tx_idx_reg == data_n + 4'h1)) ? tx_parity : 1'b1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= TX_IDLE;
      tx_idx_reg <= 4'h0;
      tx_shift_reg <= 9'h000;
      tx_line_reg <= 1'b1;
    end else if (tx_load) begin
      tx_state <= TX_SEND;
      tx_idx_reg <= 4'h1;
      tx_shift_reg <= data_buffer_reg & data_mask;
      tx_line_reg <= 1'b0;
    end else if (tx_done_ev) begin
      tx_state <= TX_IDLE;
      tx_line_reg <= 1'b1;
    end else if (tx_bit_en && tx_busy) begin
      tx_idx_reg <= tx_idx_reg + 4'h1;
      tx_line_reg <= tx_bit;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_oe_reg <= 1'b0;
      xck_oe_reg <= 1'b0;
    end else begin
      tx_oe_reg <= tx_enable_bit || tx_busy || buf_full_reg;
      xck_oe_reg <= sync_mode_sel && xfer_clock_dir && (tx_enable_bit || rx_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  usct_rx_state_type rx_state;
  logic [3:0] rx_phase_reg, rx_idx_reg;
  logic [8:0] rx_shift_reg;
  logic rx_start, rx_sample, rx_stop_ev;

  assign rx_start = (rx_state == RX_IDLE) && rx_en_reg && !serial_rx_pin &&
                    (sync_mode_sel ? sample_edge : baud_tick);
  assign rx_sample = (rx_state == RX_RUN) &&
                     (sync_mode_sel ? sample_edge : (baud_tick && rx_phase_reg == rx_mid));
  // second stop bit is never looked at
  assign rx_stop_ev = rx_sample && (rx_idx_reg == stop_pos);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= RX_IDLE;
      rx_phase_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else if (rx_start) begin
      rx_state <= RX_RUN;
      rx_phase_reg <= 4'h1;
      rx_idx_reg <= sync_mode_sel ? 4'h1 : 4'h0;
    end else if (rx_state == RX_RUN) begin
      if (baud_tick) begin
        rx_phase_reg <= (rx_phase_reg >= ps_top) ? 4'h0 : rx_phase_reg + 4'h1;
      end
      if (rx_sample) begin
        rx_idx_reg <= rx_idx_reg + 4'h1;
        if (rx_idx_reg >= 4'h1 && rx_idx_reg <= data_n) begin
          rx_shift_reg <= {serial_rx_pin, rx_shift_reg[8:1]};
        end
        if ((rx_idx_reg == 4'h0 && serial_rx_pin) || rx_stop_ev) begin
          rx_state <= RX_IDLE; // false start or frame end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      double_speed_sel <= 1'b0;
      rx_en_reg <= 1'b0;
      tx_enable_bit <= 1'b0;
      tx_bit8_reg <= 1'b0;
      char_size_field <= CS_RESET;
      sync_mode_sel <= 1'b0;
      parity_mode_field <= PAR_RESET;
      stop_bits_sel <= 1'b0;
      clock_polarity_sel <= 1'b0;
      xfer_clock_dir <= 1'b0;
      baud_divisor <= BAUD_RESET;
    end else begin
      if (wr_csa) double_speed_sel <= reg_wdata[CSA_DOUBLE];
      if (wr_csb) begin
        rx_en_reg <= reg_wdata[CSB_RX_EN];
        tx_enable_bit <= reg_wdata[CSB_TX_EN];
        char_size_field[2] <= reg_wdata[CSB_CS2];
        tx_bit8_reg <= reg_wdata[CSB_TX_BIT8];
      end
      if (wr_csc) begin
        sync_mode_sel <= reg_wdata[CSC_SYNC];
        parity_mode_field <= reg_wdata[CSC_PAR_LO +: 2];
        stop_bits_sel <= reg_wdata[CSC_STOP2];
        char_size_field[1:0] <= reg_wdata[CSC_CS_LO +: 2];
        clock_polarity_sel <= reg_wdata[CSC_POL];
      end
      if (wr_dir) xfer_clock_dir <= reg_wdata[DIR_MASTER];
      if (wr_lo) baud_divisor[7:0] <= reg_wdata;
      if (wr_hi) baud_divisor[DIV_W-1:8] <= reg_wdata[DIV_W-9:0];
    end
  end

  // flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      framing_error <= 1'b0;
      rx_bit8_reg <= 1'b0;
      rx_data_reg <= 9'h000;
      buf_full_reg <= 1'b0;
      data_buffer_reg <= 9'h000;
    end else begin
      if (tx_done_ev) tx_done_flag <= 1'b1;
      else if (wr_csa && reg_wdata[CSA_TX_DONE]) tx_done_flag <= 1'b0;
      if (rx_stop_ev) begin
        rx_done_flag <= 1'b1;
        framing_error <= !serial_rx_pin;
        rx_data_reg <= (rx_shift_reg >> (4'h9 - data_n));
        rx_bit8_reg <= rx_shift_reg[8];
      end else if (rd_data) begin
        rx_done_flag <= 1'b0;
      end
      if (wr_data) begin
        data_buffer_reg <= {tx_bit8_reg, reg_wdata};
        buf_full_reg <= 1'b1;
      end else if (tx_load) begin
        buf_full_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port and pin outputs
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  assign rd_mux = (reg_addr == ADDR_CSA) ? {rx_done_flag, tx_done_flag, !buf_full_reg, framing_error,
                                             2'b00, double_speed_sel, 1'b0} :
                  (reg_addr == ADDR_CSB) ? {3'b000, rx_en_reg, tx_enable_bit, char_size_field[2],
                                             rx_bit8_reg, tx_bit8_reg} :
                  (reg_addr == ADDR_CSC) ? {1'b0, sync_mode_sel, parity_mode_field, stop_bits_sel,
                                             char_size_field[1:0], clock_polarity_sel} :
                  (reg_addr == ADDR_DIR) ? {7'h00, xfer_clock_dir} :
                  (reg_addr == ADDR_BAUD_LO) ? baud_divisor[7:0] :
                  (reg_addr == ADDR_BAUD_HI) ? {{(16-DIV_W){1'b0}}, baud_divisor[DIV_W-1:8]} :
                  (reg_addr == ADDR_DATA) ? rx_data_reg[7:0] : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign serial_tx_out = tx_line_reg;
  assign serial_tx_oe = tx_oe_reg;
  assign xfer_clock_out = xck_int_reg;
  assign xfer_clock_oe = xck_oe_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_load_start;
    !tx_line_reg && tx_busy;
  endsequence

  a_async_bit_rate: assert property (
    (baud_tick && !sync_mode_sel && ps_reg == (double_speed_sel ? DOUBLE_TOP : NORM_TOP)) |-> (tx_bit_en ##1 (ps_reg == 4'h0)))
    else $error("asynchronous bit pace wrong for speed setting");
  a_slave_edge_delay: assert property (
    (sync_mode_sel && !xfer_clock_dir && $rose(xfer_clock_in)) |-> ##2 xck_rise)
    else $error("slave clock edge not seen two cycles later");
  a_clock_pin_dir: assert property (
    (sync_mode_sel && (tx_enable_bit || rx_en_reg)) |=> (xck_oe_reg == $past(xfer_clock_dir)))
    else $error("clock pin direction does not follow master select");
  a_edges_apart: assert property (
    !(change_edge && sample_edge))
    else $error("sample and change on the same edge");
  a_start_low: assert property (tx_load |=> s_load_start)
    else $error("frame did not begin with a low start bit");
  a_idle_high: assert property ((tx_state == TX_IDLE) |-> tx_line_reg)
    else $error("line not high while idle");
  a_parity_bit: assert property (
    (tx_bit_en && tx_busy && !tx_last && par_en && tx_idx_reg == data_n + 4'h1)
    |=> (tx_line_reg == ((^tx_shift_reg) ^ par_odd)))
    else $error("parity bit value wrong");
  a_buf_empty_clr: assert property (wr_data |=> (buf_full_reg && data_buffer_reg[7:0] == $past(reg_wdata)))
    else $error("data write did not mark buffer full");
  a_tx_pin_own: assert property (tx_enable_bit |=> serial_tx_oe)
    else $error("enabled transmitter does not drive data pin");
  a_stop_check: assert property (rx_stop_ev |=> (framing_error == !$past(serial_rx_pin) && rx_done_flag))
    else $error("framing error not taken from first stop bit");

endmodule : usct_top
`default_nettype wire

//--- tb/usct_remote_model.sv
// usct_remote_model: far-end serial station that captures frames off the data line and sends frames in
// assumes: the bench resolves the data line (pulled high when not driven); clk is the system clock
`timescale 1ns/1ps
`default_nettype none
module usct_remote_model (
  // system clock
  input wire logic clk,
  // line side
  input wire logic tx_line,
  input wire logic master_clk,
  output logic rx_line,
  output logic slave_clk
);
  initial begin
    rx_line = 1'b1;
    slave_clk = 1'b0;
  end

  // ----------------------------------------------------------------
  // sample point stepping
  // ----------------------------------------------------------------
  // mode 0 async, 1 master sampled falling, 2 slave, 3 master sampled rising
  task automatic step(input int mode, input int n);
    if (mode == 1) @(negedge master_clk);
    else if (mode == 3) @(posedge master_clk);
    else if (mode == 2) begin
      // clock at clk/9 keeps margin under the quarter-rate limit; still outside frames
      @(posedge clk) slave_clk <= 1'b1;
      repeat (4) @(posedge clk);
      slave_clk <= 1'b0;
      repeat (4) @(posedge clk);
    end else repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic capture(input int mode, input int bit_clks, input int nbits, output logic [15:0] bits,
                         output logic found);
    bits = '1;
    found = 1'b0;
    for (int i = 0; i < 3000 && !found; i++) begin
      step(mode, 1);
      found = (tx_line === 1'b0);
    end
    if (mode == 0) step(0, bit_clks / 2);
    bits[0] = tx_line;
    for (int k = 1; k < nbits; k++) begin
      step(mode, bit_clks);
      bits[k] = tx_line;
    end
  endtask : capture

  task automatic send(input logic [15:0] bits, input int nbits, input int bit_clks);
    for (int k = 0; k < nbits; k++) begin
      @(posedge clk) rx_line <= bits[k];
      repeat (bit_clks - 1) @(posedge clk);
    end
    @(posedge clk) rx_line <= 1'b1;
  endtask : send
endmodule : usct_remote_model
`default_nettype wire

//--- tb/usct_top_tb_top.sv
// usct_top_tb_top: register-level tests of frame transmit, receive and clock modes
// assumes: divisor 1 gives a baud tick every 2 clk, so an async bit is 32 clk (16 double)
`timescale 1ns/1ps
`default_nettype none
module usct_top_tb_top;
  import usct_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, serial_tx_out, serial_tx_oe, xfer_clock_out, xfer_clock_oe;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic rx_line, slave_clk, tx_line;
  int errors = 0;
  int n_checks = 0;

  // undriven data pin idles high through its pull-up
  assign tx_line = serial_tx_oe ? serial_tx_out : 1'b1;

  usct_top usct_top_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx_pin(rx_line), .serial_tx_out(serial_tx_out),
    .serial_tx_oe(serial_tx_oe), .xfer_clock_in(slave_clk), .xfer_clock_out(xfer_clock_out),
    .xfer_clock_oe(xfer_clock_oe));
  usct_remote_model usct_remote_model_i (.clk(clk), .tx_line(tx_line), .master_clk(xfer_clock_out),
    .rx_line(rx_line), .slave_clk(slave_clk));

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // expected line bits: start, data lsb first, optional parity, stops
  function automatic logic [15:0] frame(input logic [8:0] d, input int nb, input int par, input int st2,
                                        output int n);
    logic [15:0] f;
    logic [8:0] m;
    m = d & ((9'h1 << nb) - 9'h1);
    f = '1;
    f[0] = 1'b0;
    for (int k = 0; k < nb; k++) f[k + 1] = m[k];
    n = nb + 1;
    if (par >= 2) begin
      f[n] = (^m) ^ (par == 3);
      n++;
    end
    n = n + 1 + st2;
    return f;
  endfunction : frame

  // ----------------------------------------------------------------
  // scenario tasks
  // ----------------------------------------------------------------
  task automatic run_tx(input logic [7:0] csc, input logic [7:0] csb, input logic [7:0] csa, input int mode,
                        input int bit_clks, input logic [8:0] d, input int nb, input int par, input int st2);
    logic [15:0] got, exp, mask;
    logic found;
    int n;
    exp = frame(d, nb, par, st2, n);
    mask = (16'h1 << n) - 16'h1;
    reg_write(ADDR_CSC, csc);
    reg_write(ADDR_CSA, csa);
    reg_write(ADDR_CSB, csb);
    reg_write(ADDR_DATA, d[7:0]);
    if (mode == 2) begin
      reg_read(ADDR_CSA, rd);
      chk(rd[CSA_TX_EMPTY], 1'b0);
    end
    usct_remote_model_i.capture(mode, bit_clks, n, got, found);
    chk(found, 1'b1);
    chk(got & mask, exp & mask);
    if (mode != 2) begin
      repeat (bit_clks + 40) @(posedge clk);
      reg_read(ADDR_CSA, rd);
      chk(rd[6:5], 2'h3);
    end
  endtask : run_tx

  task automatic rx_case(input logic [7:0] csc, input logic [7:0] csa, input int bit_clks, input logic [7:0] d,
                         input int st2, input int bad, input logic fe);
    logic [15:0] f;
    int n;
    f = frame({1'b0, d}, 8, 0, st2, n);
    if (bad > 0) f[bad] = 1'b0;
    reg_write(ADDR_CSC, csc);
    reg_write(ADDR_CSA, csa);
    usct_remote_model_i.send(f, n, bit_clks);
    repeat (bit_clks) @(posedge clk);
    reg_read(ADDR_CSA, rd);
    chk({rd[CSA_RX_DONE], rd[CSA_FRAME_ERR]}, {1'b1, fe});
    reg_read(ADDR_DATA, rd);
    chk(rd, d);
    if (bad > 0) begin
      // a low stop bit held a whole bit time reads as a new start: let that frame drain
      repeat (12 * bit_clks) @(posedge clk);
      reg_read(ADDR_DATA, rd);
    end
  endtask : rx_case

  // ----------------------------------------------------------------
  // clock, reset, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    reg_read(ADDR_CSC, rd);
    chk(rd, 8'h06);
    reg_read(3'h7, rd);
    chk(rd, 8'h00);
    reg_write(ADDR_BAUD_HI, 8'h00);
    reg_write(ADDR_BAUD_LO, 8'h01);
    run_tx(8'h06, 8'h18, 8'h40, 0, 32, 9'h0a5, 8, 0, 0);
    run_tx(8'h28, 8'h18, 8'h40, 0, 32, 9'h0f3, 5, 2, 1);
    run_tx(8'h32, 8'h18, 8'h42, 0, 16, 9'h02c, 6, 3, 0);
    run_tx(8'h04, 8'h18, 8'h40, 0, 32, 9'h05a, 7, 0, 0);
    run_tx(8'h26, 8'h1d, 8'h40, 0, 32, 9'h13c, 9, 2, 0);
    run_tx(8'h16, 8'h18, 8'h40, 0, 32, 9'h0c3, 8, 1, 0);
    rx_case(8'h06, 8'h40, 32, 8'h96, 0, 0, 1'b0);
    rx_case(8'h06, 8'h40, 32, 8'h3c, 0, 9, 1'b1);
    rx_case(8'h0e, 8'h40, 32, 8'h71, 1, 10, 1'b0);
    rx_case(8'h06, 8'h42, 16, 8'he8, 0, 0, 1'b0);
    reg_write(ADDR_DIR, 8'h01);
    run_tx(8'h46, 8'h08, 8'h42, 1, 0, 9'h0b2, 8, 0, 0);
    chk(xfer_clock_oe, 1'b1);
    run_tx(8'h47, 8'h08, 8'h40, 3, 0, 9'h04d, 8, 0, 0);
    reg_write(ADDR_DIR, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(xfer_clock_oe, 1'b0);
    run_tx(8'h46, 8'h08, 8'h40, 2, 0, 9'h0e1, 8, 0, 0);
    report_and_stop();
  end
endmodule : usct_top_tb_top
`default_nettype wire
